//--- rtl/host_interface_select.v
`include "host_if_select_map.vh"
`default_nettype none
module host_interface_select #(
  parameter DW = 8,
  parameter FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire          i_ref_clk,
  input  wire          i_reset_n,
  // Straps
  input  wire          i_if_select_strap,
  input  wire          i_safe_boot_strap_n,
  // Shared pins
  input  wire          i_pin_tx_miso,
  output reg           o_pin_tx_miso,
  output reg           o_pin_tx_miso_oe,
  input  wire          i_pin_rx_mosi,
  input  wire          i_pin_scl_sclk,
  input  wire          i_pin_sda_cs_n,
  output reg           o_pin_sda,
  output reg           o_pin_sda_oe,
  // UART configuration
  input  wire [15:0]   i_uart_divider,
  // Outbound message bytes from the core
  input  wire [DW-1:0] i_tx_data,
  input  wire          i_tx_valid,
  output reg           o_tx_ready,
  // Inbound bytes toward the core
  output reg  [DW-1:0] o_rx_data,
  output reg           o_rx_valid,
  // Status
  output reg           o_strap_done,
  output reg           o_spi_selected,
  output reg           o_i2c_slave_channel_en,
  output reg           o_safe_boot,
  output reg           o_rtc_reset_n
);
  // Two-stage synchronisers for all pins except i_pin_tx_miso
  reg [1:0] s_sel, s_sb, s_rx, s_clk, s_cs;
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_sel <= 2'h3;
      s_sb  <= 2'h3;
      s_rx  <= 2'h3;
      s_clk <= 2'h3;
      s_cs  <= 2'h3;
    end else begin
      s_sel <= {s_sel[0], i_if_select_strap};
      s_sb  <= {s_sb[0], i_safe_boot_strap_n};
      s_rx  <= {s_rx[0], i_pin_rx_mosi};
      s_clk <= {s_clk[0], i_pin_scl_sclk};
      s_cs  <= {s_cs[0], i_pin_sda_cs_n};
    end
  end

  // Strap capture after reset release; RTC reset held until done
  reg [7:0] settle;
  reg       sel_uart;
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      settle         <= 8'h00;
      o_strap_done   <= 1'b0;
      sel_uart       <= `SEL_UART_I2C;
      o_safe_boot    <= 1'b0;
      o_rtc_reset_n  <= 1'b0;
    end else if (!o_strap_done) begin
      settle <= settle + 8'h01;
      if (settle == `STRAP_SETTLE_CYCLES) begin
        o_strap_done  <= 1'b1;
        sel_uart      <= s_sel[1];
        o_safe_boot   <= !s_sb[1];
        o_rtc_reset_n <= 1'b1;
      end
    end
  end

  // Mode outputs
  wire spi_mode = o_strap_done && (sel_uart == `SEL_SPI);
  wire uart_mode = o_strap_done && (sel_uart == `SEL_UART_I2C);
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_spi_selected         <= 1'b0;
      o_i2c_slave_channel_en <= 1'b0;
    end else begin
      o_spi_selected         <= spi_mode;
      o_i2c_slave_channel_en <= uart_mode;
    end
  end

  // Outbound FIFO shared by whichever port is active
  wire [DW-1:0] f_data;
  wire          f_valid;
  wire          f_ready_in;
  reg           f_pop;
  stream_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_data    (i_tx_data),
    .i_valid   (i_tx_valid && o_tx_ready),
    .o_ready   (f_ready_in),
    .o_data    (f_data),
    .o_valid   (f_valid),
    .i_ready   (f_pop)
  );
  // Ready drops for one cycle after each accepted byte, so a registered
  // ready never promises a slot that the last push has just filled
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      o_tx_ready <= 1'b0;
    else
      o_tx_ready <= f_ready_in && o_strap_done && !(i_tx_valid && o_tx_ready);
  end

  // Edge detection on synchronised link clock and receive pin
  reg  clk_d, rx_d;
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_d <= 1'b1;
      rx_d  <= 1'b1;
    end else begin
      clk_d <= s_clk[1];
      rx_d  <= s_rx[1];
    end
  end
  wire sclk_rise = s_clk[1] && !clk_d;
  wire sclk_fall = !s_clk[1] && clk_d;
  wire cs_act    = spi_mode && !s_cs[1];

  // SPI slave shift logic, mode 0, MSB first
  reg [DW-1:0] spi_sh_in, spi_sh_out;
  reg [2:0]    spi_bit;
  reg          spi_loaded;
  reg          spi_owns;                          // Shift byte still sits in the FIFO
  // UART engine
  reg [15:0]   baud_cnt;
  reg [3:0]    u_tx_bit, u_rx_bit;
  reg [DW+1:0] u_tx_sh;
  reg [DW-1:0] u_rx_sh;
  reg [15:0]   u_rx_cnt;
  reg          u_rx_busy;
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      spi_sh_in        <= {DW{1'b0}};
      spi_sh_out       <= {DW{1'b1}};
      spi_bit          <= 3'h0;
      spi_loaded       <= 1'b0;
      spi_owns         <= 1'b0;
      baud_cnt         <= 16'h0000;
      u_tx_bit         <= 4'h0;
      u_tx_sh          <= {(DW+2){1'b1}};
      u_rx_sh          <= {DW{1'b0}};
      u_rx_bit         <= 4'h0;
      u_rx_cnt         <= 16'h0000;
      u_rx_busy        <= 1'b0;
      f_pop            <= 1'b0;
      o_rx_data        <= {DW{1'b0}};
      o_rx_valid       <= 1'b0;
      o_pin_tx_miso    <= 1'b1;
      o_pin_tx_miso_oe <= 1'b0;
      o_pin_sda        <= 1'b0;
      o_pin_sda_oe     <= 1'b0;
    end else begin
      f_pop      <= 1'b0;
      o_rx_valid <= 1'b0;
      o_pin_sda     <= 1'b0;
      o_pin_sda_oe  <= 1'b0;
      if (spi_mode) begin
        // TX pin serves as MISO, driven only while selected
        o_pin_tx_miso_oe <= cs_act;
        o_pin_tx_miso    <= spi_sh_out[DW-1];
        if (!cs_act) begin
          spi_bit    <= 3'h0;
          spi_loaded <= 1'b0;
          spi_owns   <= 1'b0;
        end else begin
          // Peek only: a byte cut short by chip select stays queued
          if (!spi_loaded) begin
            spi_sh_out <= (f_valid && !f_pop) ? f_data : {DW{1'b1}};
            spi_owns   <= f_valid && !f_pop;
            spi_loaded <= 1'b1;
          end
          if (sclk_rise) begin
            spi_sh_in <= {spi_sh_in[DW-2:0], s_rx[1]};
            spi_bit   <= spi_bit + 3'h1;
            if (spi_bit == 3'h7) begin
              o_rx_data  <= {spi_sh_in[DW-2:0], s_rx[1]};
              o_rx_valid <= 1'b1;
              f_pop      <= spi_owns;
              spi_owns   <= 1'b0;
            end
          end
          if (sclk_fall && spi_loaded) begin
            if (spi_bit == 3'h0)
              spi_loaded <= 1'b0;
            else
              spi_sh_out <= {spi_sh_out[DW-2:0], 1'b1};
          end
        end
      end else if (uart_mode) begin
        // UART transmitter with configurable divider
        o_pin_tx_miso_oe <= 1'b1;
        o_pin_tx_miso    <= u_tx_sh[0];
        if (baud_cnt == 16'h0000) begin
          baud_cnt <= i_uart_divider;
          if (u_tx_bit != 4'h0) begin
            u_tx_sh  <= {1'b1, u_tx_sh[DW+1:1]};
            u_tx_bit <= u_tx_bit - 4'h1;
          end else if (f_valid && !f_pop) begin
            u_tx_sh  <= {1'b1, f_data, 1'b0};
            u_tx_bit <= 4'h9;
            f_pop    <= 1'b1;
          end
        end else begin
          baud_cnt <= baud_cnt - 16'h0001;
        end
        // UART receiver, samples mid-bit
        if (!u_rx_busy) begin
          if (!s_rx[1] && rx_d) begin
            u_rx_busy <= 1'b1;
            u_rx_cnt  <= {1'b0, i_uart_divider[15:1]};
            u_rx_bit  <= 4'h0;
          end
        end else if (u_rx_cnt != 16'h0000) begin
          u_rx_cnt <= u_rx_cnt - 16'h0001;
        end else begin
          u_rx_cnt <= i_uart_divider;
          u_rx_bit <= u_rx_bit + 4'h1;
          if (u_rx_bit == 4'h0) begin
            if (s_rx[1])
              u_rx_busy <= 1'b0;
          end else if (u_rx_bit <= 4'h8) begin
            u_rx_sh <= {s_rx[1], u_rx_sh[DW-1:1]};
          end else begin
            u_rx_busy <= 1'b0;
            if (s_rx[1]) begin
              o_rx_data  <= u_rx_sh;
              o_rx_valid <= 1'b1;
            end
          end
        end
      end else begin
        o_pin_tx_miso_oe <= 1'b0;
        o_pin_tx_miso    <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/host_if_select_map.vh
`ifndef HOST_IF_SELECT_MAP_VH
`define HOST_IF_SELECT_MAP_VH
`define STRAP_SETTLE_CYCLES 8'h10
`define SEL_UART_I2C        1'b1
`define SEL_SPI             1'b0
`define UART_DIV_RESET      16'h043D
`define SPI_MAX_HZ          3000000
`define I2C_MAX_HZ          100000
`define CLK_HZ              125000000
`endif

//--- rtl/stream_fifo.v
`default_nettype none
module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_ref_clk,
  input  wire             i_reset_n,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  assign full    = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign empty   = (wr_ptr == rd_ptr);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rd_ptr[AW-1:0]];
  // Storage write
  always @(posedge i_ref_clk) begin
    if (i_valid && !full)
      mem[wr_ptr[AW-1:0]] <= i_data;
  end
  // Pointers
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (i_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (i_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verification/host_interface_select_assertions.sv
`default_nettype none
module host_interface_select_assertions (
  // Clock, reset and watched outputs
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic o_pin_tx_miso,
  input wire logic o_pin_tx_miso_oe,
  input wire logic o_pin_sda_oe,
  input wire logic o_rx_valid,
  input wire logic o_strap_done,
  input wire logic o_spi_selected,
  input wire logic o_i2c_slave_channel_en,
  input wire logic o_safe_boot,
  input wire logic o_rtc_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Mode outputs land one edge after the latch
  sequence s_latched;
    $past(o_strap_done) && o_strap_done;
  endsequence
  // Start bit lasts at least two cycles
  sequence s_start_bit;
    !o_pin_tx_miso [*2];
  endsequence
  AST_ONE_PORT:
  assert property (s_latched |-> o_spi_selected != o_i2c_slave_channel_en) else $error("port mix");
  AST_NO_I2C:
  assert property (o_spi_selected |-> !o_i2c_slave_channel_en) else $error("i2c with spi");
  AST_SDA_IDLE:
  assert property (!o_pin_sda_oe) else $error("sda driven");
  AST_HOLD:
  assert property ($past(o_strap_done, 2) && o_strap_done |-> $stable(o_spi_selected)
    && $stable(o_safe_boot)) else $error("mode moved");
  AST_SETTLE:
  assert property ($rose(i_reset_n) |-> !o_strap_done [*8]) else $error("early latch");
  AST_RTC:
  assert property (!o_strap_done |-> !o_rtc_reset_n) else $error("rtc early");
  AST_SAFE:
  assert property (o_safe_boot |-> o_strap_done) else $error("safe early");
  AST_TX_DRIVE:
  assert property (s_latched and !o_spi_selected |-> o_pin_tx_miso_oe) else $error("tx off");
  AST_START:
  assert property ($fell(o_pin_tx_miso) && o_strap_done && !o_spi_selected |-> s_start_bit)
    else $error("short start");
  AST_RX_PULSE:
  assert property (o_rx_valid |=> !o_rx_valid) else $error("rx valid long");
endmodule
bind host_interface_select host_interface_select_assertions u_host_interface_select_assertions (.*);
`default_nettype wire

//--- verification/spi_host_model.sv
`default_nettype none
module spi_host_model (
  // Serial pins seen from the host side
  input  wire logic i_miso,
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 167;
  // Clock stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end
  // One mode 0 byte, MSB first, under 3 MHz
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    o_cs_n = 1'b0;
    #HALF;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #HALF o_sclk = 1'b1;
      rx[i] = i_miso;
      #HALF o_sclk = 1'b0;
    end
    #HALF o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line shows no stale bit
    #5400; // Byte spacing keeps throughput low
  endtask
  // One 8N1 byte toward the receive pin, LSB first
  task automatic uart_tx(input logic [7:0] d, input int bit_ns);
    o_mosi = 1'b0;
    #bit_ns;
    for (int i = 0; i < 8; i++) begin
      o_mosi = d[i];
      #bit_ns;
    end
    o_mosi = 1'b1;
    #bit_ns;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, strap = 1, safe_n = 1, txv = 0, held = 1, full_seen = 0;
  logic txo, oe, sda, sda_oe, tx_rdy, rxv, done, spi, i2c, sb, rtc, sclk, cs_n, mosi;
  logic [7:0] txd = 0, rxd, last_rx, got, e;
  logic [15:0] div = 16'h0003;
  logic [31:0] seed = 32'h5BE4FCFD;
  logic [7:0] uq[$], eq[$];
  int err_total = 0, cmp_count = 0, cyc = 0;
  wire pin = oe ? txo : ~held;
  wire sda_w = sda_oe ? sda : cs_n;
  always #4 clk = ~clk;
  host_interface_select u_host_interface_select (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_if_select_strap(strap), .i_safe_boot_strap_n(safe_n), .i_pin_tx_miso(pin),
    .o_pin_tx_miso(txo), .o_pin_tx_miso_oe(oe), .i_pin_rx_mosi(mosi),
    .i_pin_scl_sclk(sclk), .i_pin_sda_cs_n(sda_w), .o_pin_sda(sda), .o_pin_sda_oe(sda_oe),
    .i_uart_divider(div), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(tx_rdy),
    .o_rx_data(rxd), .o_rx_valid(rxv), .o_strap_done(done), .o_spi_selected(spi),
    .o_i2c_slave_channel_en(i2c), .o_safe_boot(sb), .o_rtc_reset_n(rtc));
  spi_host_model u_spi_host_model (.i_miso(pin), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  // Pin memory, captures and the hang guard
  always @(posedge clk) begin
    if (oe) held <= txo;
    if (rxv === 1'b1) last_rx <= rxd;
    if (txv && tx_rdy === 1'b0 && done === 1'b1) full_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      conclude();
    end
  end
  // UART receiver on the shared pin, LSB first
  always begin : uart_mon
    logic [7:0] b;
    @(negedge pin);
    if (spi === 1'b0 && done === 1'b1) begin
      repeat ((div + 1) / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (div + 1) @(posedge clk);
        b[i] = pin;
      end
      repeat (div + 1) @(posedge clk);
      uq.push_back(b);
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] w);
    cmp_count++;
    if (g !== w) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, w);
    end
  endtask
  // One byte into the FIFO, held until taken
  task automatic push(input logic [7:0] d);
    @(negedge clk);
    txd = d;
    txv = 1'b1;
    while (tx_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    txv = 1'b0;
    eq.push_back(d);
  endtask
  task automatic boot(input logic s, input logic b);
    @(negedge clk);
    rst_n = 1'b0;
    strap = s;
    safe_n = b;
    repeat (16) @(negedge clk);
    chk({7'h00, rtc}, 8'h00);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    chk({4'h0, spi, i2c, sb, rtc}, {4'h0, !s, s, !b, 1'b1});
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    seed = xs(seed);
    div = {14'h0000, seed[9:8]} + 16'h0002;
    boot(1'b1, 1'b1);
    strap = 1'b0;
    safe_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({4'h0, spi, i2c, sb, rtc}, 8'h05);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      push(seed[7:0]);
    end
    repeat (1000) @(posedge clk);
    chk({7'h00, full_seen}, 8'h01);
    chk(8'(uq.size()), 8'h0A);
    while (eq.size() > 0) chk(uq.pop_front(), eq.pop_front());
    seed = xs(seed);
    u_spi_host_model.uart_tx(seed[7:0], (div + 1) * 8);
    repeat (4) @(negedge clk);
    chk(last_rx, seed[7:0]);
    $display("uart test end");
    boot(1'b0, 1'b0);
    seed = xs(seed);
    push(seed[15:8]);
    e = eq.pop_front();
    u_spi_host_model.xfer(seed[7:0], got);
    chk(got, e);
    chk(last_rx, seed[7:0]);
    u_spi_host_model.xfer(8'hA5, got);
    chk(got, 8'hFF);
    chk(last_rx, 8'hA5);
    $display("spi test end");
    conclude();
  end
endmodule
`default_nettype wire
